// >>> hw/bio_exec.sv
// execution of jump, increment, increment-skip, soft interrupt and or-with-register
`timescale 1ns/100ps
`include "bio_cfg.svh"
module bio_exec
    import bio_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // decoded instruction, valid for one cycle
    input wire logic instr_valid,
    input wire bio_op_t instr_op,
    input wire logic [9:0] instr_imm,
    input wire logic [5:0] instr_reg,
    input wire logic instr_dest,
    // core state
    input wire logic [1:0] page_select_bits,
    input wire logic [7:0] file_rdata,
    // program counter
    output logic [11:0] pc_ff,
    // return stack push
    output logic stack_push_ff,
    output logic [11:0] stack_data_ff,
    // accumulator and file register write
    output logic [7:0] accumulator_ff,
    output logic file_we_ff,
    output logic [5:0] file_waddr_ff,
    output logic [7:0] file_wdata_ff,
    // zero flag
    output logic zero_we_ff,
    output logic zero_flag_ff,
    // high while the fetched instruction is being discarded
    output logic flush_ff
);
    bio_state_t state_ff;
    bio_state_t nxt_state;
    logic [7:0] alu_result;
    logic alu_zero;
    logic take;
    // decoded strobes for the instruction that is actually executed
    logic do_jump;
    logic do_swi;
    logic do_write;
    logic do_zero;

    bio_alu u_alu (
        .op(instr_op),
        .acc_val(accumulator_ff),
        .reg_val(file_rdata),
        .result(alu_result),
        .is_zero(alu_zero)
    );

    // a discarded instruction is never executed
    assign take = instr_valid && (state_ff == BIO_ST_EXEC);

    function automatic logic needs_flush(input bio_op_t op, input logic zero);
        case (op)
            BIO_OP_JMP: needs_flush = 1'h1;
            BIO_OP_SWI: needs_flush = 1'h1;
            BIO_OP_INCSZ: needs_flush = zero;
            default: needs_flush = 1'h0;
        endcase
    endfunction : needs_flush

    function automatic logic writes_data(input bio_op_t op);
        case (op)
            BIO_OP_INC: writes_data = 1'h1;
            BIO_OP_INCSZ: writes_data = 1'h1;
            BIO_OP_OR: writes_data = 1'h1;
            default: writes_data = 1'h0;
        endcase
    endfunction : writes_data

    function automatic logic sets_zero(input bio_op_t op);
        case (op)
            BIO_OP_INC: sets_zero = 1'h1;
            BIO_OP_OR: sets_zero = 1'h1;
            default: sets_zero = 1'h0;
        endcase
    endfunction : sets_zero

    assign do_jump = take && (instr_op == BIO_OP_JMP);
    assign do_swi = take && (instr_op == BIO_OP_SWI);
    assign do_write = take && writes_data(instr_op);
    // skip variant leaves the zero flag alone
    assign do_zero = take && sets_zero(instr_op);

    always_comb begin
        case (state_ff)
            BIO_ST_EXEC: begin
                nxt_state = (take && needs_flush(instr_op, alu_zero)) ? BIO_ST_FLUSH
                                                                     : BIO_ST_EXEC;
            end
            BIO_ST_FLUSH: nxt_state = BIO_ST_EXEC;
            default: nxt_state = BIO_ST_EXEC;
        endcase
    end

    // sequencer state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= BIO_ST_EXEC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // discard marker, registered so the core sees it in the slot it kills
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flush_ff <= 1'h0;
        end else begin
            flush_ff <= (nxt_state == BIO_ST_FLUSH);
        end
    end

    // program counter
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pc_ff <= `BIO_PC_RESET;
        end else if (do_jump) begin
            pc_ff <= {page_select_bits, instr_imm};
        end else if (do_swi) begin
            // vector into low bits; the top bit is not part of the vector
            pc_ff <= {pc_ff[`BIO_PC_W-1], `BIO_SWI_VECTOR};
        end else if (instr_valid) begin
            // a discarded slot still moves past its own address
            pc_ff <= pc_ff + `BIO_PC_ONE;
        end
    end

    // return stack push strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stack_push_ff <= 1'h0;
        end else begin
            stack_push_ff <= do_swi;
        end
    end

    // return address, tracked every cycle so it is ready with the strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stack_data_ff <= `BIO_PC_RESET;
        end else begin
            stack_data_ff <= pc_ff + `BIO_PC_ONE;
        end
    end

    // accumulator
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            accumulator_ff <= `BIO_ACC_RESET;
        end else if (do_write && instr_dest == `BIO_DEST_ACC) begin
            accumulator_ff <= alu_result;
        end
    end

    // file register write strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            file_we_ff <= 1'h0;
        end else begin
            file_we_ff <= do_write && (instr_dest != `BIO_DEST_ACC);
        end
    end

    // write address follows the operand; only meaningful with the strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            file_waddr_ff <= `BIO_REG_RESET;
        end else begin
            file_waddr_ff <= instr_reg;
        end
    end

    // write data
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            file_wdata_ff <= `BIO_DATA_ZERO;
        end else begin
            file_wdata_ff <= alu_result;
        end
    end

    // zero flag update strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            zero_we_ff <= 1'h0;
        end else begin
            zero_we_ff <= do_zero;
        end
    end

    // zero flag; holds when no flag-writing instruction runs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            zero_flag_ff <= 1'h0;
        end else if (do_zero) begin
            zero_flag_ff <= alu_zero;
        end
    end
endmodule : bio_exec

// >>> hw/bio_cfg.svh
// constants for the branch, increment, soft-interrupt and OR execution block
`ifndef BIO_CFG_SVH
`define BIO_CFG_SVH
`define BIO_PC_W 12
`define BIO_IMM_W 10
`define BIO_REG_AW 6
`define BIO_DATA_W 8
`define BIO_SWI_VECTOR 11'h002
`define BIO_PC_RESET 12'h000
`define BIO_ACC_RESET 8'h00
`define BIO_DATA_ONE 8'h01
`define BIO_DATA_ZERO 8'h00
`define BIO_PC_ONE 12'h001
`define BIO_DEST_ACC 1'b0
`define BIO_REG_RESET 6'h00
`endif

// >>> hw/bio_pkg.sv
// types shared by the execution block
package bio_pkg;
    typedef enum logic [4:0] {
        BIO_OP_NONE = 5'h00,
        BIO_OP_JMP = 5'h01,
        BIO_OP_INC = 5'h02,
        BIO_OP_INCSZ = 5'h04,
        BIO_OP_SWI = 5'h08,
        BIO_OP_OR = 5'h10
    } bio_op_t;
    typedef enum logic [1:0] {
        BIO_ST_EXEC = 2'h1,
        BIO_ST_FLUSH = 2'h2
    } bio_state_t;
endpackage : bio_pkg

// >>> hw/bio_alu.sv
// arithmetic for increment and inclusive OR, with zero detect
`timescale 1ns/100ps
`include "bio_cfg.svh"
module bio_alu
    import bio_pkg::*;
(
    // operands
    input wire bio_op_t op,
    input wire logic [7:0] acc_val,
    input wire logic [7:0] reg_val,
    // result
    output logic [7:0] result,
    output logic is_zero
);
    always_comb begin
        case (op)
            BIO_OP_OR: result = acc_val | reg_val;
            default: result = 8'(reg_val + `BIO_DATA_ONE);
        endcase
        is_zero = (result == `BIO_DATA_ZERO);
    end
endmodule : bio_alu

// >>> verif/bio_exec_props.sv
// assertions on the ports of the execution block
`timescale 1ns/100ps
module bio_exec_chk
    import bio_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // instruction
    input wire logic instr_valid,
    input wire bio_op_t instr_op,
    input wire logic [9:0] instr_imm,
    input wire logic instr_dest,
    input wire logic [1:0] page_select_bits,
    input wire logic [7:0] file_rdata,
    // results
    input wire logic [11:0] pc_ff,
    input wire logic stack_push_ff,
    input wire logic [11:0] stack_data_ff,
    input wire logic [7:0] accumulator_ff,
    input wire logic file_we_ff,
    input wire logic zero_we_ff,
    input wire logic zero_flag_ff,
    input wire logic flush_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // one-hot op that is taken; zero while the slot is discarded
    logic [4:0] op;
    assign op = (instr_valid && !flush_ff) ? instr_op : 5'h00;
    sequence flush_once; flush_ff ##1 !flush_ff; endsequence
    jmp_pc_a: assert property (op[0] |=>
        pc_ff == {$past(page_select_bits), $past(instr_imm)}) else $error("jump pc");
    jmp_slot_a: assert property (op[0] |=> flush_once) else $error("slot");
    slot_drop_a: assert property (flush_ff |=>
        !stack_push_ff && !file_we_ff && !zero_we_ff && $stable(accumulator_ff))
        else $error("discarded slot executed");
    dest_sel_a: assert property (op[1] || op[4] |=>
        file_we_ff == $past(instr_dest)) else $error("dest");
    inc_zero_a: assert property (op[1] |=>
        zero_we_ff && zero_flag_ff == &$past(file_rdata)) else $error("inc");
    skip_keep_a: assert property (op[2] |=>
        !zero_we_ff && flush_ff == &$past(file_rdata)) else $error("skip");
    swi_push_a: assert property (op[3] |=>
        stack_push_ff && stack_data_ff == $past(pc_ff) + 12'h001) else $error("push");
    swi_vec_a: assert property (op[3] |=>
        pc_ff[10:0] == 11'h002 ##0 flush_once) else $error("vector");
    or_zero_a: assert property (op[4] |=>
        zero_we_ff && zero_flag_ff == !($past(accumulator_ff) | $past(file_rdata)))
        else $error("or");
endmodule : bio_exec_chk
bind bio_exec bio_exec_chk i_chk (.*);

// >>> verif/tb_top.sv
// self-checking bench for the execution block
`timescale 1ns/100ps
module tb_top
    import bio_pkg::*;
;
    logic ref_clk = 1'h0, resetn = 1'h0, instr_valid = 1'h0, instr_dest = 1'h0;
    bio_op_t instr_op = BIO_OP_NONE;
    logic [9:0] instr_imm = 10'h155;
    logic [5:0] instr_reg = 6'h00, file_waddr_ff;
    logic [1:0] page_select_bits = 2'h2;
    logic [7:0] file_rdata = 8'h00, accumulator_ff, file_wdata_ff;
    logic [11:0] pc_ff, stack_data_ff;
    logic stack_push_ff, file_we_ff, zero_we_ff, zero_flag_ff, flush_ff;
    int err_total = 0, n_checks = 0;
    bio_exec i_dut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .instr_valid(instr_valid),
        .instr_op(instr_op),
        .instr_imm(instr_imm),
        .instr_reg(instr_reg),
        .instr_dest(instr_dest),
        .page_select_bits(page_select_bits),
        .file_rdata(file_rdata),
        .pc_ff(pc_ff),
        .stack_push_ff(stack_push_ff),
        .stack_data_ff(stack_data_ff),
        .accumulator_ff(accumulator_ff),
        .file_we_ff(file_we_ff),
        .file_waddr_ff(file_waddr_ff),
        .file_wdata_ff(file_wdata_ff),
        .zero_we_ff(zero_we_ff),
        .zero_flag_ff(zero_flag_ff),
        .flush_ff(flush_ff)
    );
    initial forever #10 ref_clk = ~ref_clk;
    task end_of_test;
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // one comparison; a mismatch is counted and reported
    task chk(string name, logic [27:0] e, logic [27:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    // e packs flags, value at the destination and pc
    task run(bio_op_t op, logic [7:0] rd, logic d, logic [27:0] e);
        instr_op = op;
        instr_dest = d;
        file_rdata = rd;
        @(posedge ref_clk);
        #2;
        chk("outputs", e, {3'h0, flush_ff, file_we_ff, zero_we_ff, zero_flag_ff, stack_push_ff,
            d ? file_wdata_ff : accumulator_ff, pc_ff});
    endtask : run
    task t_jump;
        run(BIO_OP_JMP, 8'h00, 1'h0, 28'h1000955);
        run(BIO_OP_INC, 8'h01, 1'h0, 28'h0000956);
    endtask : t_jump
    task t_data;
        run(BIO_OP_INC, 8'hFF, 1'h0, 28'h0600957);
        instr_reg = 6'h3F;
        run(BIO_OP_INC, 8'h3F, 1'h1, 28'h0C40958);
        chk("file_waddr", 28'h000003F, {22'h0, file_waddr_ff});
        run(BIO_OP_OR, 8'h00, 1'h1, 28'h0E00959);
        run(BIO_OP_OR, 8'h5A, 1'h0, 28'h045A95A);
    endtask : t_data
    task t_skip;
        run(BIO_OP_INCSZ, 8'hFF, 1'h0, 28'h100095B);
        run(BIO_OP_OR, 8'h80, 1'h0, 28'h000095C);
        run(BIO_OP_INCSZ, 8'h10, 1'h1, 28'h081195D);
        run(BIO_OP_SWI, 8'h00, 1'h0, 28'h1100802);
        chk("stack_data", 28'h000095E, {16'h0, stack_data_ff});
    endtask : t_skip
    // flags survive a jump; soft interrupt from a page with the top bit clear
    task t_flags;
        run(BIO_OP_INC, 8'hFF, 1'h0, 28'h0000803);
        run(BIO_OP_INC, 8'hFF, 1'h0, 28'h0600804);
        page_select_bits = 2'h1;
        instr_imm = 10'h2AA;
        run(BIO_OP_JMP, 8'h00, 1'h0, 28'h12006AA);
        run(BIO_OP_SWI, 8'h00, 1'h0, 28'h02006AB);
        run(BIO_OP_SWI, 8'h00, 1'h0, 28'h1300002);
        chk("stack_data", 28'h00006AC, {16'h0, stack_data_ff});
    endtask : t_flags
    // reset in mid-run clears the pending discard and every output
    task t_reset;
        resetn = 1'h0;
        instr_op = BIO_OP_NONE;
        @(posedge ref_clk);
        #2;
        chk("reset outputs", 28'h0, {3'h0, flush_ff, file_we_ff, zero_we_ff, zero_flag_ff,
            stack_push_ff, accumulator_ff, pc_ff});
        chk("reset ports", 28'h0, {2'h0, file_waddr_ff, file_wdata_ff, stack_data_ff});
        resetn = 1'h1;
        run(BIO_OP_OR, 8'h00, 1'h0, 28'h0600001);
    endtask : t_reset
    initial begin
        repeat (3) @(posedge ref_clk);
        #2;
        resetn = 1'h1;
        instr_valid = 1'h1;
        t_jump();
        t_data();
        t_skip();
        t_flags();
        t_reset();
        end_of_test();
    end
endmodule : tb_top
